// ### design/bdpg_pkg.sv
/*
 * Shared constants for the converter voltage-scaling, external clock sync
 * and power-good control block. Assumes a 200 MHz main clock.
 */
package bdpg_pkg;
    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int CLK_KHZ = CLK_MHZ * 1000;
    localparam int STEP0_NS = 1330;
    localparam int STEP1_NS = 2670;
    localparam int STEP2_NS = 5330;
    localparam int STEP3_NS = 10670;
    // least times, rounded up to whole cycles
    localparam int STEP0_CYC = (STEP0_NS * CLK_MHZ + 999) / 1000;
    localparam int STEP1_CYC = (STEP1_NS * CLK_MHZ + 999) / 1000;
    localparam int STEP2_CYC = (STEP2_NS * CLK_MHZ + 999) / 1000;
    localparam int STEP3_CYC = (STEP3_NS * CLK_MHZ + 999) / 1000;
    localparam int STEP_CW = 12;
    localparam int MS_CYC = CLK_KHZ;
    // ---------------------------------------------------------------
    // voltage code mapping
    // ---------------------------------------------------------------
    localparam int VCODE_BASE_MV = 600;
    localparam int VCODE_STEP_UV = 12500;
    localparam int VCODE_W = 8;
    // ---------------------------------------------------------------
    // external clock window: 3 MHz +/- 15 %
    // ---------------------------------------------------------------
    localparam int SYNC_F_KHZ = 3000;
    localparam int SYNC_TOL_PCT = 15;
    localparam int SYNC_PER_MIN = (CLK_KHZ * 100 + SYNC_F_KHZ
        * (100 + SYNC_TOL_PCT) - 1) / (SYNC_F_KHZ * (100 + SYNC_TOL_PCT));
    localparam int SYNC_PER_MAX = (CLK_KHZ * 100)
        / (SYNC_F_KHZ * (100 - SYNC_TOL_PCT));
    localparam int SYNC_DIV_W = 5;
    localparam int SYNC_DIV_LSB = 0;
    localparam int SYNC_AUTO_BIT = 5;
    localparam int SYNC_EN_BIT = 6;
    localparam int SYNC_CFG_W = 7;
    // ---------------------------------------------------------------
    // power-good assignment and delay
    // ---------------------------------------------------------------
    localparam int NCH = 5;
    localparam int PGA_RST_BIT = 5;
    localparam int PGA_DVS_BIT = 6;
    localparam int PGA_W = 7;
    localparam int PGD_W = 10;
    localparam logic [8*PGD_W-1:0] PGD_TABLE_DEF = {10'h200, 10'h080,
        10'h040, 10'h020, 10'h010, 10'h008, 10'h002, 10'h000};
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [1:0] RAMP_RST = 2'h0;
    localparam logic [2:0] PGD_RST = 3'h4;
    localparam logic [PGA_W-1:0] PGA_RST = 7'h01;
    localparam logic [VCODE_W-1:0] VPRIM_RST = 8'h30;
    localparam logic [VCODE_W-1:0] VALT_RST = 8'h18;
    localparam logic [SYNC_CFG_W-1:0] SYNC_RST = 7'h00;
    // ---------------------------------------------------------------
    // states
    // ---------------------------------------------------------------
    typedef enum logic {BDPG_RAMP_IDLE, BDPG_RAMP_UP} bdpg_ramp_e;
    typedef enum logic [1:0] {BDPG_PG_LOW, BDPG_PG_WAIT,
        BDPG_PG_REL} bdpg_pg_e;
endpackage

// ### design/bdpg_clk_check.sv
/*
 * Divides the synchronised external clock edges and checks the divided
 * period against the valid window. Assumes i_edge is a one-cycle pulse
 * per external rising edge, already in the i_mclk domain.
 */
`timescale 1ns/1ps
module bdpg_clk_check #(
    parameter int PER_MIN = bdpg_pkg::SYNC_PER_MIN,
    parameter int PER_MAX = bdpg_pkg::SYNC_PER_MAX,
    parameter int CW = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_edge,
    input wire logic i_enable,
    input wire logic [bdpg_pkg::SYNC_DIV_W-1:0] i_div,
    output logic o_valid
);
    import bdpg_pkg::*;

    logic [SYNC_DIV_W-1:0] cnt_q;
    logic [CW-1:0] per_q;
    logic armed_q;

    // a divider of zero behaves as one
    wire [SYNC_DIV_W-1:0] div_last = (i_div == '0) ? '0 : i_div - 1'b1;
    wire div_tick = i_edge && (cnt_q >= div_last);
    wire [CW-1:0] per_len = per_q + 1'b1;
    wire per_ok = (per_len >= CW'(PER_MIN)) && (per_len <= CW'(PER_MAX));
    wire per_over = per_q > CW'(PER_MAX);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
            per_q <= '0;
            armed_q <= 1'b0;
            o_valid <= 1'b0;
        end else if (!i_enable) begin
            cnt_q <= '0;
            per_q <= '0;
            armed_q <= 1'b0;
            o_valid <= 1'b0;
        end else begin
            if (i_edge) begin
                cnt_q <= div_tick ? '0 : cnt_q + 1'b1;
            end
            if (div_tick) begin
                // first divided edge only starts the measurement
                armed_q <= 1'b1;
                per_q <= '0;
                o_valid <= armed_q && per_ok;
            end else if (per_over) begin
                // clock stopped or too slow: drop validity at once
                o_valid <= 1'b0;
            end else begin
                per_q <= per_q + 1'b1;
            end
        end
    end
endmodule

// ### design/bdpg_ctrl.sv
/*
 * Converter control: dynamic voltage scaling ramp, external clock sync
 * selection and open-drain power-good generation.
 * Assumes register writes arrive as one-cycle strobes from the host
 * register logic on i_mclk, and that pins and analogue comparator flags
 * are asynchronous.
 */
// Summary of operation
// - select bit 0 targets primary setting, 1 targets alternate setting.
// - rising target raises reference one 12.5 mV code per step period.
// - step period code selects 1.33, 2.67, 5.33 or 10.67 us.
// - falling target takes the new code at once, no stepping.
// - transition starts on select toggle or rewrite of selected setting.
// - during power-up the external clock is ignored, internal used.
// - divide external clock; valid only within 3 MHz plus minus 15%.
// - auto tracking uses divided clock whenever valid, else internal.
// - manual mode uses divided clock only if valid and enabled.
// - manual mode clears enable bit when divided clock turns invalid.
// - flags report external clock valid and working clock choice.
// - channel power-good high when off, low on enable, high at target.
// - running channel drops below 90%, recovers above 95%.
// - power-good is AND of all assigned channel signals.
// - after reset only the converter channel is assigned.
// - assigned reset signal holds power-good low during power-up.
// - assigned scaling signal holds power-good low while ramping up.
// - power-good pin only pulls low or floats, never drives high.
// - programmable 0 to 512 ms release delay, default 32 ms.
// - shutdown pulls power-good low and releases interrupt pin.
// - clock valid and working clock changes raise an event both ways.
`timescale 1ns/1ps
module bdpg_ctrl #(
    parameter int MS_CYC = bdpg_pkg::MS_CYC,
    parameter logic [8*bdpg_pkg::PGD_W-1:0] PGD_TABLE =
        bdpg_pkg::PGD_TABLE_DEF
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_hardware_enable_pin,
    input wire logic i_sync_pin,
    input wire logic i_seq_busy,
    input wire logic i_dcdc_starting,
    input wire logic i_time_wr,
    input wire logic i_vsel,
    input wire logic [1:0] i_ramp_period,
    input wire logic [2:0] i_pg_delay,
    input wire logic i_vprim_wr,
    input wire logic [bdpg_pkg::VCODE_W-1:0] i_vprim,
    input wire logic i_valt_wr,
    input wire logic [bdpg_pkg::VCODE_W-1:0] i_valt,
    input wire logic i_sync_wr,
    input wire logic [bdpg_pkg::SYNC_CFG_W-1:0] i_sync_cfg,
    input wire logic i_pga_wr,
    input wire logic [bdpg_pkg::PGA_W-1:0] i_pga,
    input wire logic [bdpg_pkg::NCH-1:0] i_ch_en,
    input wire logic [bdpg_pkg::NCH-1:0] i_ch_at_target,
    input wire logic [bdpg_pkg::NCH-1:0] i_ch_below90,
    input wire logic [bdpg_pkg::NCH-1:0] i_ch_above95,
    output logic [bdpg_pkg::VCODE_W-1:0] o_vref_code,
    output logic o_dvs_ramping,
    output logic o_ext_clk_valid,
    output logic o_use_ext_clk,
    output logic o_clk_evt,
    output logic o_sync_en,
    output logic [bdpg_pkg::NCH-1:0] o_ch_pg,
    output logic o_pg_o,
    output logic o_pg_oe,
    output logic o_int_release,
    output logic o_supplies_off
);
    import bdpg_pkg::*;

    localparam int SW = 2 + 3 * NCH;
    localparam int MSW = $clog2(MS_CYC + 1);

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [SW-1:0] meta_q;
    logic [SW-1:0] sync_q;
    logic sync_prev_q;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            sync_prev_q <= 1'b0;
        end else begin
            meta_q <= {i_hardware_enable_pin, i_sync_pin, i_ch_at_target, i_ch_below90,
                i_ch_above95};
            sync_q <= meta_q;
            sync_prev_q <= sync_q[SW-2];
        end
    end
    wire hardware_enable_pin_s = sync_q[SW-1];
    wire sync_s = sync_q[SW-2];
    wire [NCH-1:0] at_tgt_s = sync_q[3*NCH-1:2*NCH];
    wire [NCH-1:0] below_s = sync_q[2*NCH-1:NCH];
    wire [NCH-1:0] above_s = sync_q[NCH-1:0];
    // external clock must stay below half of i_mclk to be seen
    wire sync_edge = sync_s && !sync_prev_q;

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    logic vsel_q;
    logic [1:0] ramp_per_q;
    logic [2:0] pgd_q;
    logic [VCODE_W-1:0] vprim_q;
    logic [VCODE_W-1:0] valt_q;
    logic [SYNC_DIV_W-1:0] sdiv_q;
    logic sauto_q;
    logic [PGA_W-1:0] pga_q;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vsel_q <= 1'b0;
            ramp_per_q <= RAMP_RST;
            pgd_q <= PGD_RST;
            vprim_q <= VPRIM_RST;
            valt_q <= VALT_RST;
            sdiv_q <= SYNC_RST[SYNC_DIV_LSB +: SYNC_DIV_W];
            sauto_q <= SYNC_RST[SYNC_AUTO_BIT];
            pga_q <= PGA_RST;
        end else begin
            if (i_time_wr) begin
                vsel_q <= i_vsel;
                ramp_per_q <= i_ramp_period;
                pgd_q <= i_pg_delay;
            end
            if (i_vprim_wr) vprim_q <= i_vprim;
            if (i_valt_wr) valt_q <= i_valt;
            if (i_sync_wr) begin
                sdiv_q <= i_sync_cfg[SYNC_DIV_LSB +: SYNC_DIV_W];
                sauto_q <= i_sync_cfg[SYNC_AUTO_BIT];
            end
            if (i_pga_wr) pga_q <= i_pga;
        end
    end

    // ---------------------------------------------------------------
    // voltage scaling ramp
    // ---------------------------------------------------------------
    wire vsel_nx = i_time_wr ? i_vsel : vsel_q;
    wire [VCODE_W-1:0] vprim_nx = i_vprim_wr ? i_vprim : vprim_q;
    wire [VCODE_W-1:0] valt_nx = i_valt_wr ? i_valt : valt_q;
    wire dvs_trig = (i_time_wr && (i_vsel != vsel_q))
        || (i_vprim_wr && !vsel_nx) || (i_valt_wr && vsel_nx);
    wire [VCODE_W-1:0] tgt_nx = vsel_nx ? valt_nx : vprim_nx;
    wire [STEP_CW-1:0] step_cyc = (ramp_per_q == 2'h0) ? STEP_CW'(STEP0_CYC)
        : (ramp_per_q == 2'h1) ? STEP_CW'(STEP1_CYC)
        : (ramp_per_q == 2'h2) ? STEP_CW'(STEP2_CYC)
        : STEP_CW'(STEP3_CYC);

    bdpg_ramp_e ramp_q;
    logic start_q;
    logic [VCODE_W-1:0] tgt_q;
    logic [VCODE_W-1:0] ref_q;
    logic [STEP_CW-1:0] step_q;
    wire step_tick = (ramp_q == BDPG_RAMP_UP)
        && (step_q == step_cyc - 1'b1);
    wire [VCODE_W-1:0] ref_inc = ref_q + 1'b1;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start_q <= 1'b0;
            tgt_q <= VPRIM_RST;
        end else begin
            start_q <= dvs_trig;
            if (dvs_trig) tgt_q <= tgt_nx;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ramp_q <= BDPG_RAMP_IDLE;
            ref_q <= VPRIM_RST;
            step_q <= '0;
        end else if (start_q) begin
            // a new target during a ramp restarts from the present code
            step_q <= '0;
            if (tgt_q > ref_q) begin
                ramp_q <= BDPG_RAMP_UP;
            end else begin
                ramp_q <= BDPG_RAMP_IDLE;
                ref_q <= tgt_q;
            end
        end else begin
            case (ramp_q)
                BDPG_RAMP_UP: begin
                    step_q <= step_tick ? '0 : step_q + 1'b1;
                    if (step_tick) begin
                        ref_q <= ref_inc;
                        if (ref_inc == tgt_q) begin
                            ramp_q <= BDPG_RAMP_IDLE;
                        end
                    end
                end
                default: step_q <= '0;
            endcase
        end
    end
    assign o_vref_code = ref_q;
    assign o_dvs_ramping = (ramp_q == BDPG_RAMP_UP);

    // ---------------------------------------------------------------
    // external clock sync
    // ---------------------------------------------------------------
    wire startup = i_seq_busy || i_dcdc_starting;
    logic chk_valid;
    logic valid_q;
    logic use_q;
    logic en_q;
    logic evt_q;

    bdpg_clk_check u_chk (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_edge(sync_edge),
        .i_enable(!startup),
        .i_div(sdiv_q),
        .o_valid(chk_valid)
    );

    wire valid_fall = valid_q && !chk_valid;
    wire use_d = !startup && chk_valid && (sauto_q || en_q);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_q <= SYNC_RST[SYNC_EN_BIT];
            valid_q <= 1'b0;
            use_q <= 1'b0;
            evt_q <= 1'b0;
        end else begin
            if (i_sync_wr) begin
                en_q <= i_sync_cfg[SYNC_EN_BIT];
            end else if (!sauto_q && valid_fall) begin
                en_q <= 1'b0;
            end
            valid_q <= chk_valid;
            use_q <= use_d;
            evt_q <= (chk_valid != valid_q) || (use_d != use_q);
        end
    end
    assign o_ext_clk_valid = valid_q;
    assign o_use_ext_clk = use_q;
    assign o_clk_evt = evt_q;
    assign o_sync_en = en_q;

    // ---------------------------------------------------------------
    // per-channel power good
    // ---------------------------------------------------------------
    logic [NCH-1:0] pg_q;
    logic [NCH-1:0] est_q;
    logic [NCH-1:0] en_prev_q;
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        always_ff @(posedge i_mclk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                pg_q[c] <= 1'b1;
                est_q[c] <= 1'b0;
                en_prev_q[c] <= 1'b0;
            end else begin
                en_prev_q[c] <= i_ch_en[c];
                if (!i_ch_en[c]) begin
                    pg_q[c] <= 1'b1;
                    est_q[c] <= 1'b0;
                end else if (!en_prev_q[c]) begin
                    pg_q[c] <= 1'b0;
                end else if (!est_q[c]) begin
                    pg_q[c] <= at_tgt_s[c];
                    est_q[c] <= at_tgt_s[c];
                end else if (pg_q[c] && below_s[c]) begin
                    pg_q[c] <= 1'b0;
                end else if (!pg_q[c] && above_s[c]) begin
                    pg_q[c] <= 1'b1;
                end
            end
        end
    end
    assign o_ch_pg = pg_q;

    // ---------------------------------------------------------------
    // power-good pin
    // ---------------------------------------------------------------
    wire and_ok = (&(pg_q | ~pga_q[NCH-1:0]))
        && !(pga_q[PGA_RST_BIT] && i_seq_busy)
        && !(pga_q[PGA_DVS_BIT] && o_dvs_ramping)
        && hardware_enable_pin_s;
    wire [PGD_W-1:0] dly_ms =
        PGD_TABLE[32'(pgd_q) * PGD_W +: PGD_W];

    bdpg_pg_e pgs_q;
    bdpg_pg_e pgs_d;
    logic [MSW-1:0] pre_q;
    logic [PGD_W-1:0] ms_q;
    logic pg_oe_q;
    logic int_rel_q;
    wire ms_tick = (pre_q == MSW'(MS_CYC - 1));
    wire dly_done = ms_tick && (ms_q + 1'b1 >= dly_ms);

    always_comb begin
        pgs_d = pgs_q;
        case (pgs_q)
            BDPG_PG_LOW: begin
                if (and_ok) begin
                    pgs_d = (dly_ms == '0) ? BDPG_PG_REL : BDPG_PG_WAIT;
                end
            end
            BDPG_PG_WAIT: begin
                if (!and_ok) pgs_d = BDPG_PG_LOW;
                else if (dly_done) pgs_d = BDPG_PG_REL;
            end
            default: begin
                if (!and_ok) pgs_d = BDPG_PG_LOW;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pgs_q <= BDPG_PG_LOW;
            pre_q <= '0;
            ms_q <= '0;
            pg_oe_q <= 1'b1;
            int_rel_q <= 1'b1;
        end else begin
            pgs_q <= pgs_d;
            if (pgs_d != BDPG_PG_WAIT || pgs_q != BDPG_PG_WAIT) begin
                pre_q <= '0;
                ms_q <= '0;
            end else if (ms_tick) begin
                pre_q <= '0;
                ms_q <= ms_q + 1'b1;
            end else begin
                pre_q <= pre_q + 1'b1;
            end
            pg_oe_q <= (pgs_d != BDPG_PG_REL);
            int_rel_q <= !hardware_enable_pin_s;
        end
    end
    // the pin is never driven high, only pulled low or floated
    assign o_pg_o = 1'b0;
    assign o_pg_oe = pg_oe_q;
    assign o_int_release = int_rel_q;
    assign o_supplies_off = int_rel_q;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    sequence s_step_due;
        start_q == 1'b0 ##0 step_tick;
    endsequence
    property p_sel_target;
        dvs_trig |=> (tgt_q == (vsel_q ? valt_q : vprim_q));
    endproperty
    a_sel_target: assert property (p_sel_target)
        else $error("target does not follow select bit");
    property p_step_size;
        s_step_due |=> (ref_q == $past(ref_inc));
    endproperty
    a_step_size: assert property (p_step_size)
        else $error("reference step is not one code");
    property p_no_early;
        (o_dvs_ramping && !start_q && !step_tick) |=> $stable(ref_q);
    endproperty
    a_no_early: assert property (p_no_early)
        else $error("reference moved between step ticks");
    property p_fall_now;
        (start_q && tgt_q <= ref_q) |=> (ref_q == $past(tgt_q))
            && !o_dvs_ramping;
    endproperty
    a_fall_now: assert property (p_fall_now)
        else $error("lower target not taken at once");
    property p_startup_int;
        startup |=> !o_use_ext_clk;
    endproperty
    a_startup_int: assert property (p_startup_int)
        else $error("external clock used during power-up");
    property p_manual_off;
        (!sauto_q && !en_q) |=> !o_use_ext_clk;
    endproperty
    a_manual_off: assert property (p_manual_off)
        else $error("external clock used while disabled");
    property p_auto_clear;
        (!sauto_q && valid_fall && !i_sync_wr) |=> !o_sync_en;
    endproperty
    a_auto_clear: assert property (p_auto_clear)
        else $error("enable bit not cleared on invalid clock");
    property p_clk_evt;
        $changed(o_use_ext_clk) || $changed(o_ext_clk_valid) |-> o_clk_evt;
    endproperty
    a_clk_evt: assert property (p_clk_evt)
        else $error("clock flag change without event");
    property p_pg_low;
        !and_ok |=> o_pg_oe ##1 (o_pg_oe || and_ok);
    endproperty
    a_pg_low: assert property (p_pg_low)
        else $error("power-good not pulled low at once");
    property p_shutdown;
        !hardware_enable_pin_s |=> o_pg_oe && o_int_release;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("shutdown did not pull power-good low");
endmodule

// ### testbench/bdpg_host_model.sv
/* host side model: register writes as one-cycle strobes
   assumes the caller waits for each write to finish */
`timescale 1ns/1ps
module bdpg_host_model (
    input wire logic i_mclk,
    output logic [4:0] o_strb,
    output logic [7:0] o_data
);
    initial begin
        o_strb = 5'h00;
        o_data = 8'h00;
    end
    // strobe index: 0 time, 1 primary, 2 alternate, 3 sync, 4 assign
    task automatic wr(input int r, input logic [7:0] d);
        @(negedge i_mclk);
        o_strb[r] = 1'h1;
        o_data = d;
        @(negedge i_mclk);
        o_strb = 5'h00;
        // stale data must not look like a held value
        o_data = ~d;
    endtask
endmodule

// ### testbench/test_bdpg_ctrl.sv
/* bench for bdpg_ctrl: power good, sync clock, voltage ramp
   assumes bdpg_pkg and bdpg_host_model are compiled first */
`timescale 1ns/1ps
module test_bdpg_ctrl;
    import bdpg_pkg::*;
    localparam int MSC = 20;
    logic i_mclk = 1'h0;
    logic i_rst_n = 1'h0;
    logic hardware_enable_pin = 1'h0;
    logic pin = 1'h0;
    logic run = 1'h0;
    logic busy = 1'h0;
    logic dstart = 1'h0;
    logic [4:0] en = 5'h00, at_t = 5'h00, b90 = 5'h00, a95 = 5'h00;
    logic [4:0] st, ch_pg;
    logic [7:0] hd, vref;
    logic ramping, valid, use_ext, evt, sync_en, pg_o, pg_oe, irel, soff;
    int n_errors = 0;
    int samples_checked = 0;
    int n_evt = 0;
    int stp[4] = '{STEP0_CYC, STEP1_CYC, STEP2_CYC, STEP3_CYC};
    int pgt[8] = '{0, 2, 8, 16, 32, 64, 128, 512};
    int k, d, cur;
    initial forever #2.5 i_mclk = ~i_mclk;
    // sync pin stands low outside bursts
    always #25 pin = run & ~pin;
    bdpg_host_model host (.i_mclk(i_mclk), .o_strb(st), .o_data(hd));
    bdpg_ctrl #(.MS_CYC(MSC)) DUT (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_hardware_enable_pin(hardware_enable_pin),
        .i_sync_pin(pin), .i_seq_busy(busy), .i_dcdc_starting(dstart),
        .i_time_wr(st[0]), .i_vsel(hd[5]), .i_ramp_period(hd[4:3]),
        .i_pg_delay(hd[2:0]), .i_vprim_wr(st[1]), .i_vprim(hd),
        .i_valt_wr(st[2]), .i_valt(hd), .i_sync_wr(st[3]),
        .i_sync_cfg(hd[6:0]), .i_pga_wr(st[4]), .i_pga(hd[6:0]),
        .i_ch_en(en), .i_ch_at_target(at_t), .i_ch_below90(b90),
        .i_ch_above95(a95), .o_vref_code(vref), .o_dvs_ramping(ramping),
        .o_ext_clk_valid(valid), .o_use_ext_clk(use_ext), .o_clk_evt(evt),
        .o_sync_en(sync_en), .o_ch_pg(ch_pg), .o_pg_o(pg_o),
        .o_pg_oe(pg_oe), .o_int_release(irel), .o_supplies_off(soff));
    task automatic chk(input string nm, input logic [15:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    function automatic int rel_cyc(input int code);
        return pgt[code] * MSC;
    endfunction
    task automatic wrap_up;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ---------------------------------------------------------------
    // monitors and ramp tracker
    // ---------------------------------------------------------------
    always @(negedge i_mclk) n_evt += (evt === 1'h1);
    always @(negedge i_mclk) chk("pg_o", pg_o, 16'h0000);
    task automatic ramp(input int c, input int n);
        int t;
        int last;
        int seen;
        logic [7:0] v;
        t = 0;
        last = 0;
        seen = 0;
        v = vref;
        while (seen < n && t < 12000) begin
            cyc(1);
            t++;
            if (vref !== v) begin
                chk("vref", vref, v + 8'h01);
                if (seen + 1 < n) chk("ramping", ramping, 16'h0001);
                if (seen + 1 < n) chk("pg_oe", pg_oe, 16'h0001);
                if (seen > 0) chk("step", 16'(t - last), 16'(stp[c]));
                seen++;
                last = t;
                v = vref;
            end
        end
        cyc(3);
        chk("vref", vref, 16'(cur));
        chk("ramping", ramping, 16'h0000);
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        k = $urandom(32'h1175);
        cyc(12);
        chk("vref", vref, 16'(VPRIM_RST));
        i_rst_n = 1'h1;
        hardware_enable_pin = 1'h1;
        cyc(4);
        chk("irel", irel, 16'h0000);
        cyc(32 * MSC - 4);
        chk("pg_oe", pg_oe, 16'h0001);
        cyc(10);
        chk("pg_oe", pg_oe, 16'h0000);
        d = 1 + $urandom % 6;
        host.wr(0, 8'(d));
        en = 5'h01;
        cyc(4);
        chk("ch_pg", ch_pg, 16'h001E);
        at_t = 5'h01;
        cyc(rel_cyc(d) - 5);
        chk("pg_oe", pg_oe, 16'h0001);
        cyc(15);
        chk("pg_oe", pg_oe, 16'h0000);
        en = 5'h03;
        cyc(4);
        chk("pg_oe", pg_oe, 16'h0000);
        en = 5'h01;
        b90 = 5'h01;
        cyc(5);
        chk("pg_oe", pg_oe, 16'h0001);
        b90 = 5'h00;
        cyc(5);
        chk("ch_pg", ch_pg, 16'h001E);
        a95 = 5'h01;
        cyc(5);
        chk("ch_pg", ch_pg, 16'h001F);
        busy = 1'h1;
        cyc(rel_cyc(d) + 5);
        chk("pg_oe", pg_oe, 16'h0000);
        host.wr(4, 8'h21);
        cyc(4);
        chk("pg_oe", pg_oe, 16'h0001);
        host.wr(3, 8'h66);
        run = 1'h1;
        cyc(400);
        chk("valid", valid, 16'h0000);
        busy = 1'h0;
        cyc(400);
        chk("valid", valid, 16'h0001);
        chk("use_ext", use_ext, 16'h0001);
        chk("evt", 16'(n_evt > 0), 16'h0001);
        dstart = 1'h1;
        cyc(4);
        chk("use_ext", use_ext, 16'h0000);
        dstart = 1'h0;
        cyc(400);
        chk("use_ext", use_ext, 16'h0001);
        k = n_evt;
        run = 1'h0;
        cyc(200);
        chk("use_ext", use_ext, 16'h0000);
        chk("evt", 16'(n_evt > k), 16'h0001);
        host.wr(3, 8'h06);
        run = 1'h1;
        cyc(400);
        chk("use_ext", use_ext, 16'h0000);
        host.wr(3, 8'h46);
        cyc(5);
        chk("use_ext", use_ext, 16'h0001);
        run = 1'h0;
        cyc(200);
        chk("sync_en", sync_en, 16'h0000);
        host.wr(3, 8'h63);
        run = 1'h1;
        cyc(400);
        chk("valid", valid, 16'h0000);
        run = 1'h0;
        host.wr(0, 8'h23);
        cyc(4);
        chk("vref", vref, 16'(VALT_RST));
        host.wr(1, 8'hF0);
        cyc(6);
        chk("vref", vref, 16'(VALT_RST));
        host.wr(4, 8'h61);
        cur = VALT_RST;
        for (int c = 0; c < 4; c++) begin
            k = 2 + $urandom % 3;
            host.wr(0, {3'h1, 2'(c), 3'h3});
            cur += k;
            host.wr(2, 8'(cur));
            ramp(c, k);
        end
        hardware_enable_pin = 1'h0;
        cyc(5);
        chk("pg_oe", pg_oe, 16'h0001);
        chk("irel", irel, 16'h0001);
        chk("soff", soff, 16'h0001);
        wrap_up();
    end
    initial begin
        #400000;
        n_errors++;
        wrap_up();
    end
endmodule
